// ==== core/lpb_pkg.sv ====
// package: command codes, timing constants and widths for the precharge/refresh logic
package lpb_pkg;
   // clock rate in MHz, used to turn nanoseconds into cycles
   localparam int CLK_MHZ = 100;
   // analog times in ns
   localparam int T_RTP_NS = 8;
   localparam int T_WR_NS = 15;
   localparam int T_RP_NS = 18;
   localparam int T_RAS_NS = 42;
   localparam int T_RC_NS = 60;
   localparam int T_RFC_NS = 130;
   localparam int T_WTR_NS = 8;
   localparam int T_REFI_NS = 3900;
   // cycle counts: least times round up
   localparam int RTP_CYC = (T_RTP_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
   localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
   localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
   localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
   localparam int WTR_CYC = (T_WTR_NS * CLK_MHZ + 999) / 1000;
   // longest refresh gap rounds down
   localparam int REF_GAP_MULT = 9;
   localparam int REF_GAP_CYC = (REF_GAP_MULT * T_REFI_NS * CLK_MHZ) / 1000;
   // defaults for burst length and latencies
   localparam int BL_DEF = 8;
   localparam int RL_DEF = 6;
   localparam int WL_DEF = 3;
   // bus and counter widths
   localparam int CA_W = 10;
   localparam int BANKS = 8;
   localparam int CNT_W = 16;
   // command opcodes taken from ca[3:0] at the rising edge
   localparam logic [3:0] OP_PRE = 4'hb;   // ca0,ca1 high, ca2 low, ca3 high
   localparam logic [3:0] OP_BST = 4'h3;   // ca0,ca1 high, ca2 low, ca3 low
   localparam logic [2:0] OP_REF = 3'h4;   // ca0,ca1 low, ca2 high
   // read: ca0 high, ca1 low, ca2 high; the h-h-l pattern belongs to pre/bst,
   // so a read with that code could never be told apart from them
   localparam logic [2:0] OP_RD = 3'h5;
   localparam logic [2:0] OP_WR = 3'h7;    // ca0,ca1,ca2 high
   localparam logic [2:0] OP_ACT_M = 3'h0; // ca0 low, ca1 high means activate
   // field positions in the rising-edge word
   localparam int BIT_ALL = 4;
   localparam int BIT_BA0 = 7;
   localparam int BIT_AP = 0;              // auto precharge, falling-edge word
   // controller command encoding on its user port
   typedef enum logic [2:0] {
      LPB_C_NOP = 3'h0,
      LPB_C_ACT = 3'h1,
      LPB_C_RD = 3'h2,
      LPB_C_WR = 3'h3,
      LPB_C_PRE = 3'h4,
      LPB_C_PREA = 3'h5,
      LPB_C_BST = 3'h6,
      LPB_C_REF = 3'h7
   } lpb_cmd_t;
endpackage

// ==== core/lpb_if.sv ====
// interface: command/address link between controller and device
`timescale 1ns/1ns
interface lpb_if;
   logic cs_n;                           // chip select, active low
   logic [lpb_pkg::CA_W-1:0] ca_r;       // rising-edge half of the ca word
   logic [lpb_pkg::CA_W-1:0] ca_f;       // falling-edge half of the ca word
   modport ctrl (output cs_n, output ca_r, output ca_f);
   modport dev (input cs_n, input ca_r, input ca_f);
endinterface

// ==== core/lpb_bank_timer.sv ====
// one bank: open flag, auto precharge delay and tRP countdown
`timescale 1ns/1ns
module lpb_bank_timer #(
   parameter int CW = lpb_pkg::CNT_W
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic act_in,          // activate this bank
   input wire logic pre_in,          // explicit precharge of this bank
   input wire logic ap_in,           // schedule auto precharge
   input wire logic [CW-1:0] ap_dly_in, // cycles until auto precharge begins
   output logic open_out,            // row open
   output logic idle_out             // precharged and tRP satisfied
);
   localparam logic [CW-1:0] RP = CW'(lpb_pkg::RP_CYC);
   logic open_r;
   logic [CW-1:0] ap_cnt_r;          // 0 means no auto precharge pending
   logic [CW-1:0] rp_cnt_r;          // remaining precharge time
   wire ap_fire = (ap_cnt_r == CW'(1));
   wire close_now = pre_in | ap_fire;

   // close starts tRP from the latest precharge of either kind
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         open_r <= 1'b0;
         ap_cnt_r <= '0;
         rp_cnt_r <= '0;
      end else if (ce_in) begin
         if (act_in) begin
            open_r <= 1'b1;
         end else if (close_now) begin
            open_r <= 1'b0;
         end
         if (ap_in) begin
            ap_cnt_r <= ap_dly_in;
         end else if (ap_cnt_r != '0) begin
            ap_cnt_r <= ap_cnt_r - CW'(1);
         end
         if (close_now) begin
            rp_cnt_r <= RP;
         end else if (rp_cnt_r != '0) begin
            rp_cnt_r <= rp_cnt_r - CW'(1);
         end
      end
   end
   assign open_out = open_r;
   assign idle_out = !open_r && (rp_cnt_r == '0) && (ap_cnt_r == '0);
endmodule

// ==== core/lpb_device.sv ====
// device end: decodes precharge, burst terminate and refresh and tracks banks
`timescale 1ns/1ns
// What this block does
// - precharge decoded from cs low and ca3..0
// - ca4 closes all, else ca9..7 bank
// - controller waits BL/2 after read to precharge
// - controller honours tRAS before, tRP after precharge
// - controller honours tRTP from last prefetch
// - controller waits WL+BL/2+tWR after write
// - ap bit sampled on every read, write
// - read ap closes after max(BL/2, tRTP)
// - controller waits tRP and tRC after read-ap
// - write ap closes tWR after last data
// - controller spaces other-bank commands after ap
// - controller spaces read to precharge by table
// - controller spaces write to precharge by table
// - precharges one cycle apart, tRP from latest
// - burst terminate decoded from cs, ca3..0
// - terminate hits last access, even spacing
// - terminate ends data RL/WL later, 2*count
// - refresh decoded, ca3 selects all banks
// - refresh needs all idle, leaves all idle
// - refresh bank address from internal counter
// - controller waits tRFC after refresh
// - controller posts at most eight refreshes
module lpb_device #(
   parameter int BL = lpb_pkg::BL_DEF,
   parameter int RL = lpb_pkg::RL_DEF,
   parameter int WL = lpb_pkg::WL_DEF
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   lpb_if.dev LINK,
   output logic [lpb_pkg::BANKS-1:0] BANK_OPEN_OUT,  // open rows
   output logic ALL_IDLE_OUT,                        // every bank precharged, tRP done
   output logic REF_BUSY_OUT,                        // refresh cycle in progress
   output logic [2:0] REF_BANK_OUT,                  // internal refresh bank counter
   output logic DATA_STOP_OUT,                       // burst cut at this edge
   output logic [4:0] EFF_BL_OUT,                    // effective burst length of last cut
   output logic ERR_OUT                              // sticky protocol violation
);
   localparam int CW = lpb_pkg::CNT_W;
   localparam int NB = lpb_pkg::BANKS;
   // read ap delay is the later of BL/2 and tRTP
   localparam int RD_AP = (BL / 2 > lpb_pkg::RTP_CYC) ? BL / 2 : lpb_pkg::RTP_CYC;
   // write ap: WL + BL/2 to last data stored, then tWR
   localparam int WR_AP = WL + BL / 2 + lpb_pkg::WR_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   wire sel = !LINK.cs_n;
   wire [3:0] op = LINK.ca_r[3:0];
   wire is_pre = sel && (op == lpb_pkg::OP_PRE);
   wire is_bst = sel && (op == lpb_pkg::OP_BST);
   wire is_ref = sel && (op[2:0] == lpb_pkg::OP_REF);
   wire is_refa = is_ref && op[3];
   wire rd_cmd = sel && (op[2:0] == lpb_pkg::OP_RD); // read, with or without ap
   wire is_wr = sel && (op[2:0] == lpb_pkg::OP_WR);
   wire is_act = sel && !op[0] && op[1];
   wire pre_all = is_pre && LINK.ca_r[lpb_pkg::BIT_ALL];
   wire [2:0] pre_bank = LINK.ca_r[lpb_pkg::BIT_BA0 +: 3];
   wire [2:0] cmd_bank = LINK.ca_r[lpb_pkg::BIT_BA0 +: 3];
   wire ap_bit = LINK.ca_f[lpb_pkg::BIT_AP];

   ////////////////////////////////////////////////////////////////////////////
   // per-bank state
   logic [NB-1:0] bank_idle;
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_bank
         wire hit = (cmd_bank == 3'(g));
         wire pre_hit = pre_all | (is_pre && (pre_bank == 3'(g)));
         wire ap_rd = rd_cmd && hit && ap_bit;
         wire ap_wr = is_wr && hit && ap_bit;
         wire [CW-1:0] dly = ap_wr ? CW'(WR_AP) : CW'(RD_AP);
         lpb_bank_timer #(.CW(CW)) u_bank (
            .clk_in(SYS_CLK_IN),
            .rst_n_in(RESETN_IN),
            .ce_in(CE_IN),
            .act_in(is_act && hit),
            .pre_in(pre_hit),
            .ap_in(ap_rd | ap_wr),
            .ap_dly_in(dly),
            .open_out(BANK_OPEN_OUT[g]),
            .idle_out(bank_idle[g])
         );
      end
   endgenerate
   assign ALL_IDLE_OUT = &bank_idle;

   ////////////////////////////////////////////////////////////////////////////
   // burst terminate tracking
   logic [CW-1:0] since_r;     // cycles since the latest read or write
   logic last_wr_r;            // latest access was a write
   logic live_r;               // an access exists to terminate
   logic [CW-1:0] stop_cnt_r;  // countdown to the data cut
   logic [4:0] eff_bl_r;
   logic err_r;
   wire access = rd_cmd | is_wr;
   wire bst_ok = is_bst && live_r && !since_r[0] && (since_r != '0);
   wire [CW-1:0] stop_lat = last_wr_r ? CW'(WL) : CW'(RL);

   // the terminate only ever looks at the latest access
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         since_r <= '0;
         last_wr_r <= 1'b0;
         live_r <= 1'b0;
      end else if (CE_IN) begin
         if (access) begin
            since_r <= CW'(1);
            last_wr_r <= is_wr;
            live_r <= 1'b1;
         end else begin
            if (since_r != '1) since_r <= since_r + CW'(1);
            if (bst_ok || since_r >= CW'(BL / 2)) live_r <= 1'b0;
         end
      end
   end

   // data stops RL or WL cycles after the terminate
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         stop_cnt_r <= '0;
         eff_bl_r <= 5'h00;
      end else if (CE_IN) begin
         if (bst_ok) begin
            stop_cnt_r <= stop_lat;
            eff_bl_r <= 5'(since_r << 1);
         end else if (stop_cnt_r != '0) begin
            stop_cnt_r <= stop_cnt_r - CW'(1);
         end
      end
   end
   assign DATA_STOP_OUT = (stop_cnt_r == CW'(1));
   assign EFF_BL_OUT = eff_bl_r;

   ////////////////////////////////////////////////////////////////////////////
   // refresh: internal bank counter walks every bank
   logic [CW-1:0] rfc_cnt_r;
   logic [2:0] ref_bank_r;
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         rfc_cnt_r <= '0;
         ref_bank_r <= 3'h0;
      end else if (CE_IN) begin
         if (is_refa && ALL_IDLE_OUT) begin
            rfc_cnt_r <= CW'(lpb_pkg::RFC_CYC);
            ref_bank_r <= 3'h0;
         end else if (rfc_cnt_r != '0) begin
            rfc_cnt_r <= rfc_cnt_r - CW'(1);
            ref_bank_r <= ref_bank_r + 3'h1;
         end
      end
   end
   assign REF_BUSY_OUT = (rfc_cnt_r != '0);
   assign REF_BANK_OUT = ref_bank_r;

   ////////////////////////////////////////////////////////////////////////////
   // sticky flag for requests the device cannot honour
   wire bad_bst = is_bst && !bst_ok;
   wire bad_ref = is_refa && !ALL_IDLE_OUT;
   wire bad_busy = sel && REF_BUSY_OUT && (is_act || is_ref);
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         err_r <= 1'b0;
      end else if (CE_IN && (bad_bst || bad_ref || bad_busy)) begin
         err_r <= 1'b1;
      end
   end
   assign ERR_OUT = err_r;
endmodule

// ==== core/lpb_ctrl.sv ====
// controller end: spaces user commands by the bank and refresh timing
`timescale 1ns/1ns
module lpb_ctrl #(
   parameter int BL = lpb_pkg::BL_DEF,
   parameter int WL = lpb_pkg::WL_DEF,
   parameter int REF_GAP = lpb_pkg::REF_GAP_CYC
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   input wire logic CMD_VALID_IN,
   input wire lpb_pkg::lpb_cmd_t CMD_IN,
   input wire logic [2:0] BANK_IN,
   input wire logic AP_IN,
   output logic CMD_READY_OUT,       // a valid command is taken this edge
   output logic REF_DUE_OUT,         // refresh gap close to its limit
   lpb_if.ctrl LINK
);
   localparam int CW = lpb_pkg::CNT_W;
   localparam int RD_PRE = BL / 2 + ((lpb_pkg::RTP_CYC > 2) ? lpb_pkg::RTP_CYC : 2) - 2;
   localparam int WR_PRE = WL + BL / 2 + lpb_pkg::WR_CYC;
   localparam int AP_CLOSE = WR_PRE + lpb_pkg::RP_CYC;
   // per-bank earliest-time counters: precharge and activate
   logic [CW-1:0] pre_wait_r [8];
   logic [CW-1:0] act_wait_r [8];
   logic [CW-1:0] rd_wait_r, wr_wait_r, rfc_r, gap_r;
   logic [2:0] ca_cmd;
   wire [CW-1:0] pw = pre_wait_r[BANK_IN];
   wire [CW-1:0] aw = act_wait_r[BANK_IN];
   logic all_pre_ok;
   always_comb begin
      all_pre_ok = 1'b1;
      for (int i = 0; i < 8; i++) if (pre_wait_r[i] != '0) all_pre_ok = 1'b0;
   end
   logic all_act_ok;
   always_comb begin
      all_act_ok = 1'b1;
      for (int i = 0; i < 8; i++) if (act_wait_r[i] != '0) all_act_ok = 1'b0;
   end
   wire ok = (CMD_IN == lpb_pkg::LPB_C_NOP) ||
      ((CMD_IN == lpb_pkg::LPB_C_ACT) && aw == '0 && rfc_r == '0) ||
      ((CMD_IN == lpb_pkg::LPB_C_RD) && rd_wait_r == '0) ||
      ((CMD_IN == lpb_pkg::LPB_C_WR) && wr_wait_r == '0) ||
      ((CMD_IN == lpb_pkg::LPB_C_PRE) && pw == '0) ||
      ((CMD_IN == lpb_pkg::LPB_C_PREA) && all_pre_ok) ||
      (CMD_IN == lpb_pkg::LPB_C_BST) ||
      ((CMD_IN == lpb_pkg::LPB_C_REF) && all_act_ok && rfc_r == '0);
   wire take = CMD_VALID_IN && CE_IN && ok;
   assign CMD_READY_OUT = CE_IN && ok;
   assign REF_DUE_OUT = (gap_r >= CW'(REF_GAP - REF_GAP / 9));

   // bank timers: set on the taken command, count down otherwise
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         for (int i = 0; i < 8; i++) begin
            pre_wait_r[i] <= '0;
            act_wait_r[i] <= '0;
         end
         rd_wait_r <= '0;
         wr_wait_r <= '0;
         rfc_r <= '0;
         gap_r <= '0;
      end else if (CE_IN) begin
         for (int i = 0; i < 8; i++) begin
            if (pre_wait_r[i] != '0) pre_wait_r[i] <= pre_wait_r[i] - CW'(1);
            if (act_wait_r[i] != '0) act_wait_r[i] <= act_wait_r[i] - CW'(1);
         end
         if (rd_wait_r != '0) rd_wait_r <= rd_wait_r - CW'(1);
         if (wr_wait_r != '0) wr_wait_r <= wr_wait_r - CW'(1);
         if (rfc_r != '0) rfc_r <= rfc_r - CW'(1);
         if (gap_r != '1) gap_r <= gap_r + CW'(1);
         if (take) begin
            unique case (CMD_IN)
               lpb_pkg::LPB_C_ACT: begin
                  pre_wait_r[BANK_IN] <= CW'(lpb_pkg::RAS_CYC);
                  act_wait_r[BANK_IN] <= CW'(lpb_pkg::RC_CYC);
               end
               lpb_pkg::LPB_C_RD: begin
                  pre_wait_r[BANK_IN] <= CW'(RD_PRE > BL / 2 ? RD_PRE : BL / 2);
                  rd_wait_r <= CW'(BL / 2);
                  wr_wait_r <= CW'(BL / 2 + 2);
                  if (AP_IN) act_wait_r[BANK_IN] <= CW'(RD_PRE + lpb_pkg::RP_CYC);
               end
               lpb_pkg::LPB_C_WR: begin
                  pre_wait_r[BANK_IN] <= CW'(WR_PRE);
                  rd_wait_r <= CW'(WL + BL / 2 + lpb_pkg::WTR_CYC);
                  wr_wait_r <= CW'(BL / 2);
                  if (AP_IN) act_wait_r[BANK_IN] <= CW'(AP_CLOSE);
               end
               lpb_pkg::LPB_C_PRE: act_wait_r[BANK_IN] <= CW'(lpb_pkg::RP_CYC);
               lpb_pkg::LPB_C_PREA: begin
                  for (int i = 0; i < 8; i++) act_wait_r[i] <= CW'(lpb_pkg::RP_CYC);
               end
               lpb_pkg::LPB_C_REF: begin
                  rfc_r <= CW'(lpb_pkg::RFC_CYC);
                  gap_r <= '0;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ca encoding of the taken command, registered onto the link
   always_comb begin
      unique case (CMD_IN)
         lpb_pkg::LPB_C_RD: ca_cmd = lpb_pkg::OP_RD;
         lpb_pkg::LPB_C_WR: ca_cmd = lpb_pkg::OP_WR;
         lpb_pkg::LPB_C_REF: ca_cmd = lpb_pkg::OP_REF;
         default: ca_cmd = lpb_pkg::OP_RD;
      endcase
   end
   wire [3:0] op = (CMD_IN == lpb_pkg::LPB_C_PRE || CMD_IN == lpb_pkg::LPB_C_PREA) ?
      lpb_pkg::OP_PRE : (CMD_IN == lpb_pkg::LPB_C_BST) ? lpb_pkg::OP_BST :
      (CMD_IN == lpb_pkg::LPB_C_ACT) ? 4'h2 : (CMD_IN == lpb_pkg::LPB_C_REF) ? 4'hc :
      {1'b0, ca_cmd};
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         LINK.cs_n <= 1'b1;
         LINK.ca_r <= '0;
         LINK.ca_f <= '0;
      end else if (CE_IN) begin
         LINK.cs_n <= !(take && CMD_IN != lpb_pkg::LPB_C_NOP);
         LINK.ca_r <= {BANK_IN, 2'b00, (CMD_IN == lpb_pkg::LPB_C_PREA), op};
         LINK.ca_f <= {9'h000, AP_IN};
      end
   end
endmodule

// ==== test/lpb_link_sva.sv ====
// checker: command spacing on the link and the device's reaction to it
`timescale 1ns/1ns
module lpb_link_sva #(
   parameter int BL = 8,
   parameter int WL = 3,
   parameter int RL = 6,
   parameter int REF_GAP = 200
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic cs_n,
   input wire logic [lpb_pkg::CA_W-1:0] ca_r,
   input wire logic [lpb_pkg::CA_W-1:0] ca_f,
   input wire logic [lpb_pkg::BANKS-1:0] BANK_OPEN_OUT,
   input wire logic REF_BUSY_OUT,
   input wire logic DATA_STOP_OUT
);
   // quiet span after a write before a precharge-all may come
   localparam int WR_PREA = WL + BL / 2 + lpb_pkg::WTR_CYC - 1;
   localparam int RP1 = lpb_pkg::RP_CYC - 1; // quiet span after a precharge
   localparam int RL1 = RL + 1;              // registered stop may trail by one edge
   ////////////////////////////////////////////////////////////////////////////////
   // command decode; reads are not told apart from other words here
   wire is_pre = !cs_n && ca_r[3:0] == lpb_pkg::OP_PRE;
   wire is_bst = !cs_n && ca_r[3:0] == lpb_pkg::OP_BST;
   wire is_ref = !cs_n && ca_r[2:0] == lpb_pkg::OP_REF;
   wire is_wr = !cs_n && ca_r[2:0] == lpb_pkg::OP_WR;
   wire is_act = !cs_n && ca_r[1:0] == 2'b10;
   wire [2:0] cmd_bank = ca_r[9:7]; // bank field of the rising word
   logic [15:0] ref_age_r;          // cycles since the last refresh, saturating
   logic ref_seen_r;                // a refresh has been seen since reset
   ////////////////////////////////////////////////////////////////////////////////
   // refresh age counter
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         ref_age_r <= 16'h0000;
         ref_seen_r <= 1'b0;
      end else if (is_ref) begin
         ref_age_r <= 16'h0001;
         ref_seen_r <= 1'b1;
      end else if (ref_age_r != 16'hffff) begin
         ref_age_r <= ref_age_r + 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   sequence s_prea;
      is_pre && ca_r[4];
   endsequence
   sequence s_pre1;
      is_pre && !ca_r[4];
   endsequence
   property p_wr_prea;
      is_wr |-> not (##[1:WR_PREA] s_prea);
   endproperty
   property p_prea_act;
      s_prea |-> not (##[1:RP1] is_act);
   endproperty
   property p_pre_ref;
      is_pre |-> not (##[1:RP1] is_ref);
   endproperty
   property p_ref_rfc;
      (is_act || is_ref) && ref_seen_r |-> ref_age_r >= lpb_pkg::RFC_CYC;
   endproperty
   property p_ref_gap;
      ref_seen_r |-> ref_age_r <= REF_GAP;
   endproperty
   property p_pre_close;
      s_pre1 |=> !BANK_OPEN_OUT[$past(cmd_bank)];
   endproperty
   property p_prea_close;
      s_prea |=> BANK_OPEN_OUT == '0;
   endproperty
   property p_ref_busy;
      is_ref |=> REF_BUSY_OUT [*8];
   endproperty
   property p_bst_stop;
      is_bst |-> ##[RL:RL1] DATA_STOP_OUT;
   endproperty
   a_wr_prea: assert property (p_wr_prea) else $error("precharge-all soon after write");
   a_prea_act: assert property (p_prea_act) else $error("activate inside tRP");
   a_pre_ref: assert property (p_pre_ref) else $error("refresh inside tRP");
   a_ref_rfc: assert property (p_ref_rfc) else $error("command inside tRFC");
   a_ref_gap: assert property (p_ref_gap) else $error("refresh gap too long");
   a_pre_close: assert property (p_pre_close) else $error("bank left open");
   a_prea_close: assert property (p_prea_close) else $error("banks left open");
   a_ref_busy: assert property (p_ref_busy) else $error("refresh busy dropped");
   a_bst_stop: assert property (p_bst_stop) else $error("burst not cut");
endmodule

// ==== test/lpddr2_precharge_bst_refresh_tb.sv ====
// testbench: controller and device on one link, a second device driven raw
`timescale 1ns/1ns
module lpddr2_precharge_bst_refresh_tb;
   localparam int REF_GAP = 400; // short refresh gap keeps the run brief
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic rstn2 = 1'b0; // own reset of the raw-driven device
   logic ce = 1'b1;
   logic vld = 1'b0;
   lpb_pkg::lpb_cmd_t cmd = lpb_pkg::LPB_C_NOP;
   logic [2:0] bank = 3'h0;
   logic ap = 1'b0;
   logic rdy, due, idle, busy, stop, err, err2;
   logic [7:0] opn, opn2;
   logic [4:0] ebl;
   logic [2:0] rbk; // internal refresh bank counter
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int t_rd, t_bst, t_stop, t_ref, n;
   lpb_if lk ();
   lpb_if lk2 ();
   lpb_ctrl #(.REF_GAP(REF_GAP)) lpb_ctrl_i (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce),
      .CMD_VALID_IN(vld), .CMD_IN(cmd), .BANK_IN(bank), .AP_IN(ap), .CMD_READY_OUT(rdy),
      .REF_DUE_OUT(due), .LINK(lk.ctrl));
   lpb_device lpb_device_i (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce), .LINK(lk.dev),
      .BANK_OPEN_OUT(opn), .ALL_IDLE_OUT(idle), .REF_BUSY_OUT(busy), .REF_BANK_OUT(rbk),
      .DATA_STOP_OUT(stop), .EFF_BL_OUT(ebl), .ERR_OUT(err));
   lpb_device lpb_device_raw_i (.SYS_CLK_IN(clk), .RESETN_IN(rstn2), .CE_IN(ce),
      .LINK(lk2.dev), .BANK_OPEN_OUT(opn2), .ALL_IDLE_OUT(), .REF_BUSY_OUT(),
      .REF_BANK_OUT(), .DATA_STOP_OUT(), .EFF_BL_OUT(), .ERR_OUT(err2));
   lpb_link_sva #(.REF_GAP(REF_GAP)) lpb_link_sva_i (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
      .cs_n(lk.cs_n), .ca_r(lk.ca_r), .ca_f(lk.ca_f), .BANK_OPEN_OUT(opn),
      .REF_BUSY_OUT(busy), .DATA_STOP_OUT(stop));
   ////////////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   // compare and count
   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // user-port request held until taken, then the link word is checked
   task automatic issue(input lpb_pkg::lpb_cmd_t c, input logic [2:0] b, input logic a);
      int k;
      k = 0;
      @(posedge clk);
      vld <= 1'b1;
      cmd <= c;
      bank <= b;
      ap <= a;
      do begin
         @(negedge clk);
         k++;
      end while (rdy !== 1'b1 && k < 200);
      @(posedge clk);
      vld <= 1'b0;
      @(negedge clk);
      chk("cs", 10'h0, {9'h0, lk.cs_n});
      case (c)
         lpb_pkg::LPB_C_PRE: chk("pre", {b, 7'h0b}, lk.ca_r & 10'h39f);
         lpb_pkg::LPB_C_PREA: chk("prea", 10'h01b, lk.ca_r & 10'h01f);
         lpb_pkg::LPB_C_BST: chk("bst", 10'h003, lk.ca_r & 10'h00f);
         lpb_pkg::LPB_C_REF: chk("ref", 10'h00c, lk.ca_r & 10'h00f);
         lpb_pkg::LPB_C_RD, lpb_pkg::LPB_C_WR: chk("ap", {9'h0, a}, {9'h0, lk.ca_f[0]});
         default: ;
      endcase
   endtask
   // raw word on the second link for one cycle; called just after a rising edge
   task automatic raw(input logic c, input logic [9:0] w);
      lk2.cs_n <= c;
      lk2.ca_r <= w;
      lk2.ca_f <= ~w;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // cycle stamps and hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         wrap_up();
      end
   end
   always @(negedge clk) begin
      if (!lk.cs_n && lk.ca_r[3:0] == lpb_pkg::OP_BST) t_bst = cyc + 1;
      // the pulse stands before the edge that samples it, so stamp that edge
      if (stop === 1'b1) t_stop = cyc + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      lk2.cs_n = 1'b1;
      lk2.ca_r = 10'h000;
      lk2.ca_f = 10'h000;
      repeat (20) @(posedge clk);
      chk("cs_rst", 10'h1, {9'h0, lk.cs_n});
      rstn <= 1'b1;
      rstn2 <= 1'b1;
      // every bank code of a single precharge
      for (int b = 0; b < 8; b++) issue(lpb_pkg::LPB_C_ACT, b[2:0], 1'b0);
      @(negedge clk);
      chk("open", 10'h0ff, {2'h0, opn});
      for (int b = 0; b < 8; b++) begin
         issue(lpb_pkg::LPB_C_PRE, b[2:0], 1'b0);
         @(negedge clk);
         chk("close", {2'h0, 8'hfe << b}, {2'h0, opn});
      end
      for (int b = 0; b < 8; b += 3) issue(lpb_pkg::LPB_C_ACT, b[2:0], 1'b0);
      issue(lpb_pkg::LPB_C_PREA, 3'h0, 1'b0);
      @(negedge clk);
      chk("prea_all", 10'h000, {2'h0, opn});
      repeat (3) @(negedge clk);
      chk("idle", 10'h001, {9'h0, idle});
      // auto precharge on reads and writes
      issue(lpb_pkg::LPB_C_ACT, 3'h2, 1'b0);
      issue(lpb_pkg::LPB_C_RD, 3'h2, 1'b0);
      repeat (10) @(negedge clk);
      chk("rd_open", 10'h1, {9'h0, opn[2]});
      issue(lpb_pkg::LPB_C_RD, 3'h2, 1'b1);
      repeat (4) @(negedge clk);
      chk("rdap_early", 10'h1, {9'h0, opn[2]});
      repeat (2) @(negedge clk);
      chk("rdap", 10'h0, {9'h0, opn[2]});
      issue(lpb_pkg::LPB_C_ACT, 3'h5, 1'b0);
      issue(lpb_pkg::LPB_C_WR, 3'h5, 1'b1);
      repeat (9) @(negedge clk);
      chk("wrap_early", 10'h1, {9'h0, opn[5]});
      repeat (2) @(negedge clk);
      chk("wrap", 10'h0, {9'h0, opn[5]});
      // read cut short by a terminate
      issue(lpb_pkg::LPB_C_ACT, 3'h1, 1'b0);
      issue(lpb_pkg::LPB_C_RD, 3'h1, 1'b0);
      t_rd = cyc + 1;
      issue(lpb_pkg::LPB_C_BST, 3'h1, 1'b0);
      repeat (12) @(negedge clk);
      chk("bst_even", 10'h0, 10'((t_bst - t_rd) % 2));
      chk("eff_bl", 10'((t_bst - t_rd) * 2), {5'h0, ebl});
      n = t_stop - t_bst;
      chk("stop", 10'h1, {9'h0, n == lpb_pkg::RL_DEF || n == lpb_pkg::RL_DEF + 1});
      issue(lpb_pkg::LPB_C_PREA, 3'h0, 1'b0);
      // raw device: odd terminate spacing, then refresh with a bank open
      @(posedge clk);
      raw(1'b0, 10'h002);
      raw(1'b0, 10'h007);
      raw(1'b0, 10'h003);
      raw(1'b1, 10'h3fc);
      @(negedge clk);
      chk("bst_odd", 10'h1, {9'h0, err2});
      @(posedge clk);
      rstn2 <= 1'b0;
      @(posedge clk);
      rstn2 <= 1'b1;
      @(negedge clk);
      chk("err_clr", 10'h0, {7'h0, err2, |opn2, 1'b0});
      @(posedge clk);
      raw(1'b0, 10'h002);
      raw(1'b0, 10'h00c);
      raw(1'b1, 10'h3f3);
      @(negedge clk);
      chk("ref_open", 10'h1, {9'h0, err2});
      // refresh through the controller
      issue(lpb_pkg::LPB_C_REF, 3'h0, 1'b0);
      t_ref = cyc + 1;
      @(negedge clk);
      chk("busy", 10'h1, {9'h0, busy});
      issue(lpb_pkg::LPB_C_ACT, 3'h4, 1'b0);
      chk("rfc", 10'h1, {9'h0, cyc + 1 - t_ref >= lpb_pkg::RFC_CYC});
      chk("busy_end", 10'h0, {9'h0, busy});
      chk("ref_bank", 10'(lpb_pkg::RFC_CYC % 8), {7'h0, rbk});
      issue(lpb_pkg::LPB_C_PRE, 3'h4, 1'b0);
      n = 0;
      while (due !== 1'b1 && n < REF_GAP) begin
         @(negedge clk);
         n++;
      end
      chk("due", 10'h1, {9'h0, due});
      issue(lpb_pkg::LPB_C_REF, 3'h0, 1'b0);
      repeat (20) @(negedge clk);
      chk("err", 10'h0, {9'h0, err});
      wrap_up();
   end
endmodule
